// File: rtl/spfs_top.sv
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module spfs_top (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Shared pads
   input wire logic [spfs_pkg::NPAD-1:0] i_pad,
   output logic [spfs_pkg::NPAD-1:0] o_pad,
   output logic [spfs_pkg::NPAD-1:0] o_pad_oe_n,
   // Dedicated pins
   input wire logic i_ext_reset_n,
   input wire logic [spfs_pkg::NSTRAP-1:0] i_mode_strap,
   output logic o_ext_reset_req,
   output logic [spfs_pkg::NSTRAP-1:0] o_mode,
   output logic o_mode_valid,
   // Peripheral outputs toward pads
   input wire logic [1:0] i_reload_timer_out,
   input wire logic [1:0] i_serial_tx,
   input wire logic [1:0] i_serial_clock_out,
   input wire logic i_pulse_gen0,
   input wire logic i_pulse_gen4,
   input wire logic i_pulse_gen5,
   input wire logic i_pulse_gen6,
   input wire logic i_pulse_gen7,
   input wire logic i_can_transmit_out,
   input wire logic [spfs_pkg::NWAVE-1:0] i_waveform_out,
   // Pad levels toward peripherals
   output logic [1:0] o_serial_rx,
   output logic [1:0] o_serial_clock_in,
   output logic o_can_receive_in,
   output logic o_converter_trigger_in,
   output logic [2:0] o_capture_trigger_in,
   output logic o_pulse_width_in,
   output logic o_waveform_control_in,
   output logic o_free_run_ext_clock,
   output logic [2:0] o_ext_irq_in
);
   localparam int NP = spfs_pkg::NPAD;

   logic [NP-1:0] port_data_reg;
   logic [NP-1:0] port_dir_reg;
   logic [spfs_pkg::NFUNC-1:0] func_reg;
   logic [NP-1:0] pad_sync;
   logic [spfs_pkg::NSTRAP:0] pin_sync;
   logic [1:0] strap_cnt_reg;
   spfs_pkg::spfs_strap_t strap_state_reg;
   logic [NP-1:0] fn_oe;
   logic [NP-1:0] fn_val;
   logic [NP-1:0] port_ok;
   logic req;
   logic [31:0] rd_next;
   logic [5:0] idx;

   // Pad inputs pass two flops before use
   spfs_sync #(.W(NP), .INIT('0)) u_pad_sync (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_d(i_pad),
      .o_q(pad_sync)
   );

   // Reset pin and straps pass two flops before use
   spfs_sync #(.W(spfs_pkg::NSTRAP + 1), .INIT('1)) u_pin_sync (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_d({i_ext_reset_n, i_mode_strap}),
      .o_q(pin_sync)
   );

   // Bus request decode
   assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign idx = i_wb_adr[7:2];

   function automatic logic [NP-1:0] merge(input logic [NP-1:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] sel);
      logic [31:0] tmp;
      tmp = {{(32 - NP){1'b0}}, old};
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            tmp[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return tmp[NP-1:0];
   endfunction

   // Port data register
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         port_data_reg <= spfs_pkg::RST_PORT_DATA;
      end else if (req && i_wb_we && idx == spfs_pkg::IDX_PORT_DATA) begin
         port_data_reg <= merge(port_data_reg, i_wb_dat, i_wb_sel);
      end
   end

   // Port direction register
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         port_dir_reg <= spfs_pkg::RST_PORT_DIR;
      end else if (req && i_wb_we && idx == spfs_pkg::IDX_PORT_DIR) begin
         port_dir_reg <= merge(port_dir_reg, i_wb_dat, i_wb_sel);
      end
   end

   // Function select register picks port or peripheral use
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         func_reg <= spfs_pkg::RST_FUNC_SEL;
      end else if (req && i_wb_we && idx == spfs_pkg::IDX_FUNC_SEL) begin
         func_reg <= merge(func_reg, i_wb_dat, i_wb_sel);
      end
   end

   // Read mux; unmapped words read zero
   always_comb begin
      rd_next = 32'h00000000;
      case (idx)
         spfs_pkg::IDX_PORT_DATA: rd_next[NP-1:0] = port_data_reg;
         spfs_pkg::IDX_PORT_DIR: rd_next[NP-1:0] = port_dir_reg;
         spfs_pkg::IDX_FUNC_SEL: rd_next[NP-1:0] = func_reg;
         spfs_pkg::IDX_PIN_LEVEL: rd_next[NP-1:0] = pad_sync;
         spfs_pkg::IDX_MODE: begin
            rd_next[spfs_pkg::NSTRAP-1:0] = o_mode;
            rd_next[spfs_pkg::NSTRAP] = o_mode_valid;
         end
         default: rd_next = 32'h00000000;
      endcase
   end

   // Bus answer one cycle after request
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= req;
         if (req && !i_wb_we) begin
            o_wb_dat <= rd_next;
         end
      end
   end

   // Pad ownership and output value per function
   always_comb begin
      fn_oe = '0;
      fn_val = '0;
      port_ok = '1;
      fn_oe[spfs_pkg::PAD_RT1] = func_reg[spfs_pkg::EN_RT1];
      fn_val[spfs_pkg::PAD_RT1] = i_reload_timer_out[0];
      fn_oe[spfs_pkg::PAD_RT2] = func_reg[spfs_pkg::EN_RT2];
      fn_val[spfs_pkg::PAD_RT2] = i_reload_timer_out[1];
      fn_oe[spfs_pkg::PAD_TX0] = func_reg[spfs_pkg::EN_TX0];
      fn_val[spfs_pkg::PAD_TX0] = i_serial_tx[0];
      fn_oe[spfs_pkg::PAD_TX1] = func_reg[spfs_pkg::EN_TX1];
      fn_val[spfs_pkg::PAD_TX1] = i_serial_tx[1];
      fn_oe[spfs_pkg::PAD_SERIAL_CLOCK_PIN] = func_reg[spfs_pkg::EN_SERIAL_CLOCK_PIN];
      fn_val[spfs_pkg::PAD_SERIAL_CLOCK_PIN] = i_serial_clock_out[0];
      fn_oe[spfs_pkg::PAD_SCK1] = func_reg[spfs_pkg::EN_SCK1];
      fn_val[spfs_pkg::PAD_SCK1] = i_serial_clock_out[1];
      // CAN receive use blocks the port driver on this pad; interrupt 6 use does not
      fn_oe[spfs_pkg::PAD_PG5] = func_reg[spfs_pkg::EN_PG5];
      fn_val[spfs_pkg::PAD_PG5] = i_pulse_gen5;
      port_ok[spfs_pkg::PAD_PG5] = !func_reg[spfs_pkg::EN_PG5] &&
                                   !func_reg[spfs_pkg::EN_CANRX];
      // CAN transmit outranks pulse generator 6
      fn_oe[spfs_pkg::PAD_PG6] = func_reg[spfs_pkg::EN_CANTX] ||
                                 func_reg[spfs_pkg::EN_PG6];
      fn_val[spfs_pkg::PAD_PG6] = func_reg[spfs_pkg::EN_CANTX] ?
                                  i_can_transmit_out : i_pulse_gen6;
      port_ok[spfs_pkg::PAD_TRG] = !(func_reg[spfs_pkg::EN_TRG] &&
                                     func_reg[spfs_pkg::EN_CAP2]);
      fn_oe[spfs_pkg::PAD_PG0] = func_reg[spfs_pkg::EN_PG0];
      fn_val[spfs_pkg::PAD_PG0] = i_pulse_gen0;
      fn_oe[spfs_pkg::PAD_PG4] = func_reg[spfs_pkg::EN_PG4];
      fn_val[spfs_pkg::PAD_PG4] = i_pulse_gen4;
      fn_oe[spfs_pkg::PAD_PG7] = func_reg[spfs_pkg::EN_PG7];
      fn_val[spfs_pkg::PAD_PG7] = i_pulse_gen7;
      for (int w = 0; w < spfs_pkg::NWAVE; w++) begin
         fn_oe[spfs_pkg::PAD_WAVE + w] = func_reg[spfs_pkg::EN_WAVE];
         fn_val[spfs_pkg::PAD_WAVE + w] = i_waveform_out[w];
      end
   end

   // Pad drivers: peripheral first, port bit otherwise
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pad <= '0;
         o_pad_oe_n <= '1;
      end else begin
         for (int p = 0; p < NP; p++) begin
            o_pad[p] <= fn_oe[p] ? fn_val[p] : port_data_reg[p];
            o_pad_oe_n[p] <= !(fn_oe[p] ||
                               (port_ok[p] && port_dir_reg[p]));
         end
      end
   end

   // Serial receive and clock input feeds
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_serial_rx <= {2{spfs_pkg::IDLE_HIGH}};
         o_serial_clock_in <= {2{spfs_pkg::IDLE_HIGH}};
      end else begin
         o_serial_rx[0] <= func_reg[spfs_pkg::EN_RX0] ?
                           pad_sync[spfs_pkg::PAD_RX0] :
                           spfs_pkg::IDLE_HIGH;
         o_serial_rx[1] <= func_reg[spfs_pkg::EN_RX1] ?
                           pad_sync[spfs_pkg::PAD_RX1] :
                           spfs_pkg::IDLE_HIGH;
         o_serial_clock_in[0] <= pad_sync[spfs_pkg::PAD_SERIAL_CLOCK_PIN];
         o_serial_clock_in[1] <= pad_sync[spfs_pkg::PAD_SCK1];
      end
   end

   // Shared receive, trigger and capture feeds
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_can_receive_in <= spfs_pkg::IDLE_HIGH;
         o_converter_trigger_in <= spfs_pkg::IDLE_LOW;
         o_capture_trigger_in <= '0;
      end else begin
         o_can_receive_in <= func_reg[spfs_pkg::EN_CANRX] ?
                             pad_sync[spfs_pkg::PAD_PG5] :
                             spfs_pkg::IDLE_HIGH;
         o_converter_trigger_in <= func_reg[spfs_pkg::EN_TRG] ?
                                   pad_sync[spfs_pkg::PAD_TRG] :
                                   spfs_pkg::IDLE_LOW;
         o_capture_trigger_in[2] <= func_reg[spfs_pkg::EN_CAP2] ?
                                    pad_sync[spfs_pkg::PAD_TRG] :
                                    spfs_pkg::IDLE_LOW;
         o_capture_trigger_in[0] <= func_reg[spfs_pkg::EN_CAP0] ?
                                    pad_sync[spfs_pkg::PAD_CAP0] :
                                    spfs_pkg::IDLE_LOW;
         o_capture_trigger_in[1] <= func_reg[spfs_pkg::EN_CAP1] ?
                                    pad_sync[spfs_pkg::PAD_CAP1] :
                                    spfs_pkg::IDLE_LOW;
      end
   end

   // Timer input feeds
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pulse_width_in <= spfs_pkg::IDLE_LOW;
         o_waveform_control_in <= spfs_pkg::IDLE_LOW;
         o_free_run_ext_clock <= spfs_pkg::IDLE_LOW;
      end else begin
         o_pulse_width_in <= func_reg[spfs_pkg::EN_PWI] ?
                             pad_sync[spfs_pkg::PAD_PWI] :
                             spfs_pkg::IDLE_LOW;
         o_waveform_control_in <= func_reg[spfs_pkg::EN_WCTL] ?
                                  pad_sync[spfs_pkg::PAD_WCTL] :
                                  spfs_pkg::IDLE_LOW;
         o_free_run_ext_clock <= func_reg[spfs_pkg::EN_FRCK] ?
                                 pad_sync[spfs_pkg::PAD_FRCK] :
                                 spfs_pkg::IDLE_LOW;
      end
   end

   // External interrupt feeds
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ext_irq_in <= '0;
      end else begin
         o_ext_irq_in[0] <= func_reg[spfs_pkg::EN_IRQ0] ?
                            pad_sync[spfs_pkg::PAD_IRQ0] :
                            spfs_pkg::IDLE_LOW;
         o_ext_irq_in[1] <= func_reg[spfs_pkg::EN_IRQ6] ?
                            pad_sync[spfs_pkg::PAD_PG5] :
                            spfs_pkg::IDLE_LOW;
         o_ext_irq_in[2] <= func_reg[spfs_pkg::EN_IRQ7] ?
                            pad_sync[spfs_pkg::PAD_PG7] :
                            spfs_pkg::IDLE_LOW;
      end
   end

   // Dedicated reset pin request
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ext_reset_req <= 1'b1;
      end else begin
         o_ext_reset_req <= !pin_sync[spfs_pkg::NSTRAP];
      end
   end

   // Strap capture once the synchroniser has filled
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         strap_state_reg <= spfs_pkg::SPFS_STRAP_WAIT;
         strap_cnt_reg <= 2'h0;
         o_mode <= '0;
         o_mode_valid <= 1'b0;
      end else begin
         case (strap_state_reg)
            spfs_pkg::SPFS_STRAP_WAIT: begin
               if (strap_cnt_reg == 2'(spfs_pkg::NSYNC)) begin
                  o_mode <= pin_sync[spfs_pkg::NSTRAP-1:0];
                  o_mode_valid <= 1'b1;
                  strap_state_reg <= spfs_pkg::SPFS_STRAP_DONE;
               end else begin
                  strap_cnt_reg <= strap_cnt_reg + 2'h1;
               end
            end
            spfs_pkg::SPFS_STRAP_DONE: begin
               o_mode_valid <= 1'b1;
            end
            default: begin
               strap_state_reg <= spfs_pkg::SPFS_STRAP_WAIT;
            end
         endcase
      end
   end
endmodule

// File: rtl/spfs_pkg.sv
package spfs_pkg;
   // Pad count and strap count
   localparam int NPAD = 26;
   localparam int NSTRAP = 3;
   localparam int NSYNC = 2;
   localparam int NFUNC = 26;

   // Pad positions
   localparam int PAD_RT1 = 0;
   localparam int PAD_RT2 = 1;
   localparam int PAD_TX0 = 2;
   localparam int PAD_RX0 = 3;
   localparam int PAD_SERIAL_CLOCK_PIN = 4;
   localparam int PAD_TX1 = 5;
   localparam int PAD_RX1 = 6;
   localparam int PAD_SCK1 = 7;
   localparam int PAD_PG5 = 8;
   localparam int PAD_PG6 = 9;
   localparam int PAD_TRG = 10;
   localparam int PAD_PWI = 11;
   localparam int PAD_WCTL = 12;
   localparam int PAD_FRCK = 13;
   localparam int PAD_CAP0 = 14;
   localparam int PAD_CAP1 = 15;
   localparam int PAD_PG0 = 16;
   localparam int PAD_PG4 = 17;
   localparam int PAD_PG7 = 18;
   localparam int PAD_WAVE = 19;
   localparam int PAD_IRQ0 = 25;
   localparam int NWAVE = 6;

   // Function select bit positions
   localparam int EN_RT1 = 0;
   localparam int EN_RT2 = 1;
   localparam int EN_TX0 = 2;
   localparam int EN_RX0 = 3;
   localparam int EN_SERIAL_CLOCK_PIN = 4;
   localparam int EN_TX1 = 5;
   localparam int EN_RX1 = 6;
   localparam int EN_SCK1 = 7;
   localparam int EN_PG5 = 8;
   localparam int EN_CANRX = 9;
   localparam int EN_IRQ6 = 10;
   localparam int EN_PG6 = 11;
   localparam int EN_CANTX = 12;
   localparam int EN_TRG = 13;
   localparam int EN_CAP2 = 14;
   localparam int EN_PWI = 15;
   localparam int EN_WCTL = 16;
   localparam int EN_FRCK = 17;
   localparam int EN_CAP0 = 18;
   localparam int EN_CAP1 = 19;
   localparam int EN_PG0 = 20;
   localparam int EN_PG4 = 21;
   localparam int EN_PG7 = 22;
   localparam int EN_IRQ7 = 23;
   localparam int EN_WAVE = 24;
   localparam int EN_IRQ0 = 25;

   // Register word indices (byte address is four times)
   localparam logic [5:0] IDX_PORT_DATA = 6'h00;
   localparam logic [5:0] IDX_PORT_DIR = 6'h01;
   localparam logic [5:0] IDX_FUNC_SEL = 6'h02;
   localparam logic [5:0] IDX_PIN_LEVEL = 6'h03;
   localparam logic [5:0] IDX_MODE = 6'h04;

   // Reset values
   localparam logic [NPAD-1:0] RST_PORT_DATA = 26'h0000000;
   localparam logic [NPAD-1:0] RST_PORT_DIR = 26'h0000000;
   localparam logic [NFUNC-1:0] RST_FUNC_SEL = 26'h0000000;

   // Idle levels fed to peripherals while their input is deselected
   localparam logic IDLE_HIGH = 1'b1;
   localparam logic IDLE_LOW = 1'b0;

   typedef enum logic [1:0] {
      SPFS_STRAP_WAIT,
      SPFS_STRAP_DONE
   } spfs_strap_t;
endpackage

// File: rtl/spfs_sync.sv
`timescale 1ns/1ps
module spfs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_reg;

   // Two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_reg <= INIT;
         o_q <= INIT;
      end else begin
         meta_reg <= i_d;
         o_q <= meta_reg;
      end
   end
endmodule

// File: testbench/spfs_top_assertions.sv
`timescale 1ns/1ps
module spfs_checker (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Bus
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic o_wb_ack,
   // Pads and pins
   input wire logic [spfs_pkg::NPAD-1:0] i_pad,
   input wire logic [spfs_pkg::NPAD-1:0] o_pad,
   input wire logic [spfs_pkg::NPAD-1:0] o_pad_oe_n,
   input wire logic i_ext_reset_n,
   input wire logic [spfs_pkg::NSTRAP-1:0] i_mode_strap,
   input wire logic o_ext_reset_req,
   input wire logic [spfs_pkg::NSTRAP-1:0] o_mode,
   input wire logic o_mode_valid,
   // Peripheral side
   input wire logic [1:0] i_reload_timer_out,
   input wire logic [1:0] i_serial_tx,
   input wire logic [1:0] i_serial_clock_out,
   input wire logic i_pulse_gen6,
   input wire logic i_can_transmit_out,
   input wire logic [spfs_pkg::NWAVE-1:0] i_waveform_out,
   input wire logic [1:0] o_serial_rx,
   input wire logic o_converter_trigger_in,
   input wire logic [2:0] o_ext_irq_in
);
   // Shadow of the function select, one edge behind the register
   logic [25:0] f;
   logic [31:0] wm;
   logic [2:0] c;
   assign wm = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}},
      {8{i_wb_sel[0]}}};
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         f <= '0;
      end else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack &&
         i_wb_adr[7:2] == spfs_pkg::IDX_FUNC_SEL) begin
         f <= (f & ~wm[25:0]) | (i_wb_dat[25:0] & wm[25:0]);
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         c <= 3'h0;
      end else if (c != 3'h7) begin
         c <= c + 3'h1;
      end
   end
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_ack;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   property p_ack;
      s_req |=> s_ack;
   endproperty
   property p_rt1;
      f[0] |-> !o_pad_oe_n[0] && o_pad[0] == $past(i_reload_timer_out[0]);
   endproperty
   property p_tx0;
      f[2] |-> !o_pad_oe_n[2] && o_pad[2] == $past(i_serial_tx[0]);
   endproperty
   property p_sck1;
      f[7] |-> !o_pad_oe_n[7] && o_pad[7] == $past(i_serial_clock_out[1]);
   endproperty
   property p_cantx;
      f[12] |-> !o_pad_oe_n[9] && o_pad[9] == $past(i_can_transmit_out);
   endproperty
   property p_pg6;
      f[11] && !f[12] |-> !o_pad_oe_n[9] && o_pad[9] == $past(i_pulse_gen6);
   endproperty
   property p_wave;
      f[24] |-> o_pad_oe_n[24:19] == 6'h00 &&
         o_pad[24:19] == $past(i_waveform_out);
   endproperty
   property p_share;
      (f[8] || f[9]) |-> o_pad_oe_n[8] == !f[8];
   endproperty
   property p_rx;
      o_serial_rx[0] == (f[3] ? $past(i_pad[3], 3) : 1'b1);
   endproperty
   property p_trig;
      f[13] && f[14] |-> o_pad_oe_n[10] &&
         o_converter_trigger_in == $past(i_pad[10], 3);
   endproperty
   property p_irq;
      o_ext_irq_in[0] == (f[25] && $past(i_pad[25], 3));
   endproperty
   property p_rst;
      i_ext_reset_n [*4] |-> !o_ext_reset_req;
   endproperty
   property p_mode;
      c == 3'h7 |-> o_mode_valid && o_mode == i_mode_strap;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus ack is not one pulse");
   a_rt1: assert property (p_rt1)
      else $error("timer pad wrong");
   a_tx0: assert property (p_tx0)
      else $error("serial data pad wrong");
   a_sck1: assert property (p_sck1)
      else $error("serial clock pad wrong");
   a_cantx: assert property (p_cantx)
      else $error("can pad wrong");
   a_pg6: assert property (p_pg6)
      else $error("pulse pad wrong");
   a_wave: assert property (p_wave)
      else $error("wave pads wrong");
   a_share: assert property (p_share)
      else $error("shared pad driven by port");
   a_rx: assert property (p_rx)
      else $error("receive feed wrong");
   a_trig: assert property (p_trig)
      else $error("trigger pad wrong");
   a_irq: assert property (p_irq)
      else $error("interrupt feed wrong");
   a_rst: assert property (p_rst)
      else $error("reset request with pin high");
   a_mode: assert property (p_mode)
      else $error("mode not captured");
endmodule
bind spfs_top spfs_checker spfs_checker_inst (.*);

// File: testbench/spfs_board_model.sv
`timescale 1ns/1ps
module spfs_board_model (
   // Clock
   input wire logic i_clk_sys,
   // Device side of the pads
   input wire logic [spfs_pkg::NPAD-1:0] i_pad_out,
   input wire logic [spfs_pkg::NPAD-1:0] i_pad_oe_n,
   // Board drivers
   input wire logic [spfs_pkg::NPAD-1:0] i_drv_en,
   input wire logic [spfs_pkg::NPAD-1:0] i_drv_val,
   // Wire level
   output logic [spfs_pkg::NPAD-1:0] o_pad_level
);
   // A released line shows the inverse of its last level
   logic [spfs_pkg::NPAD-1:0] last_reg = '0;
   always_ff @(posedge i_clk_sys) begin
      for (int i = 0; i < spfs_pkg::NPAD; i++) begin
         if (!i_pad_oe_n[i] || i_drv_en[i]) begin
            last_reg[i] <= o_pad_level[i];
         end
      end
   end
   always_comb begin
      for (int i = 0; i < spfs_pkg::NPAD; i++) begin
         if (!i_pad_oe_n[i]) begin
            o_pad_level[i] = i_pad_out[i];
         end else if (i_drv_en[i]) begin
            o_pad_level[i] = i_drv_val[i];
         end else begin
            o_pad_level[i] = ~last_reg[i];
         end
      end
   end
endmodule

// File: testbench/test_shared_pin_function_select.sv
`timescale 1ns/1ps
module test_shared_pin_function_select;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m;} spfs_note_t;
   localparam logic [31:0] A_DT = {24'h0, spfs_pkg::IDX_PORT_DATA, 2'b00};
   localparam logic [31:0] A_DR = {24'h0, spfs_pkg::IDX_PORT_DIR, 2'b00};
   localparam logic [31:0] A_FS = {24'h0, spfs_pkg::IDX_FUNC_SEL, 2'b00};
   localparam logic [31:0] A_PL = {24'h0, spfs_pkg::IDX_PIN_LEVEL, 2'b00};
   localparam logic [31:0] A_MD = {24'h0, spfs_pkg::IDX_MODE, 2'b00};
   int ens[18] = '{0, 1, 2, 5, 4, 7, 20, 21, 8, 11, 22, 12, 24, 24, 24, 24,
      24, 24};
   int pads[18] = '{0, 1, 2, 5, 4, 7, 16, 17, 8, 9, 18, 9, 19, 20, 21, 22,
      23, 24};
   int sfs[5] = '{32'h1800, 32'h200, 32'h0, 32'h6000, 32'h2000};
   int spd[5] = '{9, 8, 8, 10, 10};
   int sex[5] = '{1, 0, 1, 0, 1};
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, wb_we = 1'b0, ext_n = 1'b1, smp = 1'b0;
   logic [31:0] adr = '0, dat = '0, rdat, b, ev, mk;
   logic [2:0] strap = 3'h5;
   logic [3:0] sel = '0;
   logic [17:0] pv = '0;
   logic [25:0] drv_en = '0, drv_val = '0, pad_in, pad_out, pad_oe_n;
   logic ack, rst_req, mvalid, can_rx, trig, pwi, wctl, frck;
   logic [1:0] rx, sck_in;
   logic [2:0] mode, cap, irq;
   spfs_note_t q[$];
   int errors = 0, total_checks = 0, cyc_cnt = 0, seed = 32'he13a;
   spfs_top spfs_top_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(wb_we), .i_wb_adr(adr),
      .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_pad(pad_in), .o_pad(pad_out), .o_pad_oe_n(pad_oe_n),
      .i_ext_reset_n(ext_n), .i_mode_strap(strap), .o_ext_reset_req(rst_req),
      .o_mode(mode), .o_mode_valid(mvalid), .i_reload_timer_out(pv[1:0]),
      .i_serial_tx(pv[3:2]), .i_serial_clock_out(pv[5:4]),
      .i_pulse_gen0(pv[6]), .i_pulse_gen4(pv[7]), .i_pulse_gen5(pv[8]),
      .i_pulse_gen6(pv[9]), .i_pulse_gen7(pv[10]),
      .i_can_transmit_out(pv[11]), .i_waveform_out(pv[17:12]),
      .o_serial_rx(rx), .o_serial_clock_in(sck_in), .o_can_receive_in(can_rx),
      .o_converter_trigger_in(trig), .o_capture_trigger_in(cap),
      .o_pulse_width_in(pwi), .o_waveform_control_in(wctl),
      .o_free_run_ext_clock(frck), .o_ext_irq_in(irq));
   spfs_board_model spfs_board_model_inst (.i_clk_sys(i_clk_sys),
      .i_pad_out(pad_out), .i_pad_oe_n(pad_oe_n), .i_drv_en(drv_en),
      .i_drv_val(drv_val), .o_pad_level(pad_in));
   initial begin
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge i_clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      wb_we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      @(posedge i_clk_sys);
      while (ack !== 1'b1) @(posedge i_clk_sys);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input string nm, input logic [31:0] a,
      input logic [31:0] e, input logic [31:0] m);
      q.push_back('{nm, e, m});
      wb(1'b0, a, 32'h0, 4'h0);
   endtask
   task automatic sample(input string nm, input logic [31:0] e,
      input logic [31:0] m);
      q.push_back('{nm, e, m});
      @(posedge i_clk_sys);
      smp <= 1'b1;
      @(posedge i_clk_sys);
      smp <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got);
      spfs_note_t n;
      if (q.size() == 0) begin
         return;
      end
      n = q.pop_front();
      total_checks++;
      if ((got & n.m) !== (n.e & n.m)) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n.nm, n.e & n.m, got & n.m);
      end
   endtask
   // Result watcher and hang guard
   always @(posedge i_clk_sys) begin
      if (ack === 1'b1 && wb_we === 1'b0) chk(rdat);
      if (smp) chk({16'h0, rst_req, sck_in, rx, can_rx, trig, cap, pwi, wctl,
         frck, irq});
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      rd("data", A_DT, 32'h0, 32'hFFFFFFFF);
      rd("dir", A_DR, 32'h0, 32'hFFFFFFFF);
      rd("fsel", A_FS, 32'h0, 32'hFFFFFFFF);
      rd("mode", A_MD, 32'hD, 32'hFFFFFFFF);
      b = $random(seed);
      wb(1'b1, A_FS, b, 4'h5);
      rd("fsel", A_FS, b & 32'h00FF00FF, 32'hFFFFFFFF);
      wr(32'h3C, b);
      rd("hole", 32'h3C, 32'h0, 32'hFFFFFFFF);
      $display("test registers done");
      for (int k = 0; k < 18; k++) begin
         pv <= 18'($random(seed));
         wr(A_DR, 32'h0);
         wr(A_FS, 32'h1 << ens[k]);
         repeat (4) @(posedge i_clk_sys);
         ev = 32'(pv[k]) << pads[k];
         mk = 32'h1 << pads[k];
         rd("pad", A_PL, ev, mk);
         wr(A_FS, 32'h0);
         wr(A_DR, 32'h1 << pads[k]);
         wr(A_DT, ~(32'(pv[k]) << pads[k]));
         repeat (4) @(posedge i_clk_sys);
         rd("port", A_PL, ~ev, mk);
      end
      $display("test outputs done");
      pv <= 18'h800;
      for (int k = 0; k < 5; k++) begin
         drv_en <= 26'h1 << spd[k];
         wr(A_DR, 32'h1 << spd[k]);
         wr(A_DT, 32'h1 << spd[k]);
         wr(A_FS, sfs[k]);
         repeat (4) @(posedge i_clk_sys);
         ev = sex[k] << spd[k];
         mk = 32'h1 << spd[k];
         rd("shared", A_PL, ev, mk);
      end
      $display("test shared done");
      b = $random(seed);
      drv_en <= '1;
      drv_val <= b[25:0];
      wr(A_DR, 32'h0);
      wr(A_FS, 32'h28FE648);
      repeat (4) @(posedge i_clk_sys);
      ev = {17'h0, b[7], b[4], b[6], b[3], b[8], b[10], b[10],
         b[15], b[14], b[11], b[12], b[13], b[18], b[8], b[25]};
      sample("feeds", ev, 32'h7E00);
      sample("feeds", ev, 32'h81FF);
      wr(A_FS, 32'h0);
      repeat (4) @(posedge i_clk_sys);
      ev = {17'h0, b[7], b[4], 13'h1C00};
      sample("idle", ev, 32'hFFFF);
      ext_n <= 1'b0;
      repeat (5) @(posedge i_clk_sys);
      sample("reset pin", 32'h8000, 32'h8000);
      ext_n <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      sample("reset pin", 32'h0, 32'h8000);
      $display("test feeds done");
      i_resetn <= 1'b0;
      strap <= 3'h2;
      repeat (8) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      rd("mode", A_MD, 32'hA, 32'hFFFFFFFF);
      rd("data", A_DT, 32'h0, 32'hFFFFFFFF);
      $display("test reset done");
      final_report();
   end
endmodule
